// ### lpm_sequencer.sv
/*
 * Low-power mode and reset sequencer: Sleep, Power-down, Deep power-down,
 * wake-up counting, flash wake timer, reset merge and brownout handling.
 * Assumes all inputs are synchronous to clk_sys (10 MHz); the oscillator
 * ready flags come from analogue monitors outside this block.
 */
// How it works
// RULE1: Sleep stops oscillator, gates clocks, holds state
// RULE2: Sleep disables RC output, keeps it powered
// RULE3: Real-time clock oscillator runs during Sleep
// RULE4: Sleep entry powers off and disconnects PLL
// RULE5: Sleep entry clears processor and USB dividers
// RULE6: Reset or clockless interrupt ends Sleep
// RULE7: Flash stays powered through Sleep
// RULE8: RC source wake resumes after 4 cycles
// RULE9: Main oscillator wake resumes after 4096 cycles
// RULE10: Software reprograms PLL and dividers after wake
// RULE11: Power-down also stops RC oscillator and flash
// RULE12: Power-down wake waits RC start, 4 cycles
// RULE13: Flash blocked until flash wake counter expires
// RULE14: Deep power-down drops regulator, resumes like reset
// RULE15: Deep power-down wakes on alarm or reset
// RULE16: Four reset sources merge into chip reset
// RULE17: Reset held until pin, oscillator, count, flash
// RULE18: Released processor fetches from address zero
// RULE19: First brownout stage raises interrupt and status
// RULE20: Second brownout stage holds chip reset
// RULE21: External interrupts optionally wake Power-down
// RULE22: Alarm output can restore power when unpowered
// RULE23: Run from RC oscillator after power-up, wake
// RULE24: Reset during low power restarts reset sequence
`timescale 1ns/100ps
module lpm_sequencer
	import lpm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        reset_pin,
	input  wire logic        watchdog_reset,
	input  wire logic        power_on_reset,
	input  wire logic        brownout_stage1,
	input  wire logic        brownout_stage2,
	input  wire logic        osc_running,
	input  wire logic        flash_init_done,
	input  wire logic [1:0]  mode_req,
	input  wire logic        main_osc_selected,
	input  wire logic        rtc_alarm,
	input  wire logic        rtc_irq,
	input  wire logic [3:0]  ext_irq,
	input  wire logic [3:0]  ext_wake_enable,
	input  wire logic        main_powered,
	output logic             chip_reset,
	output logic [31:0]      fetch_address,
	output logic             clocks_enabled,
	output logic             main_osc_enable,
	output logic             rc_osc_powered,
	output logic             rc_osc_output_enable,
	output logic             rtc_osc_enable,
	output logic             pll_enable,
	output logic             pll_connect,
	output logic             div_clear,
	output logic [7:0]       processor_clock_div,
	output logic [7:0]       usb_clock_div,
	output logic             flash_powered,
	output logic             flash_access_allowed,
	output logic             regulator_enable,
	output logic             use_rc_source,
	output logic             brownout_irq,
	output logic             brownout_status,
	output logic             rtc_alarm_out
);

	// Module state
	typedef struct packed
	{
		seq_state_t  state;
		mode_req_t   mode;       // Mode being held or woken from
		logic        was_main;   // Main oscillator was the source
		logic        flash_wait; // Flash wake timer running
		logic        flash_ok;
		logic [9:0]  start_cnt;  // RC start-up time left
		logic        rc_source;
		logic        brownout_flag;
	} seq_t;

	seq_t st;      // Registered state
	seq_t next_st; // Next state

	logic        any_reset;  // Merged reset sources
	logic        wake_event; // Wake for the current mode
	logic        cnt_load;   // Load the wake/reset counter
	logic [12:0] cnt_value;
	logic        cnt_step;
	logic        cnt_done;
	logic        fl_load;
	logic        fl_done;
	logic        rc_tick;    // RC-rate enable pulse
	logic        osc_tick;   // Step for the wake counter

	localparam logic [9:0] START_CLKS = 10'(RC_START_CLKS);
	localparam logic [12:0] FLASH_COUNT = 13'(FLASH_WAKE_RC);

	////////////////////////////////////////////////////////////////////

	// Wake source decode shared by Sleep and Power-down
	function automatic logic wake_src(input logic [3:0] irq, input logic [3:0] en,
		input logic rtc);
		wake_src = rtc | (|(irq & en));
	endfunction

	////////////////////////////////////////////////////////////////////

	// Merge of the three sources; stage two brownout joins them
	assign any_reset = reset_pin | watchdog_reset | power_on_reset
		| brownout_stage2; // RULE16 RULE20

	// Deep power-down answers only the alarm; others use interrupts
	always_comb
	begin
		case (st.mode)
			REQ_DPD:   wake_event = rtc_alarm; // RULE15
			REQ_PDOWN: wake_event = wake_src(ext_irq, ext_wake_enable, rtc_irq); // RULE21
			REQ_SLEEP: wake_event = wake_src(ext_irq, ext_wake_enable, rtc_irq); // RULE6
			default:   wake_event = 1'b0;
		endcase
	end

	// Counter steps on the RC tick, or every cycle for the main oscillator
	assign osc_tick = st.was_main ? 1'b1 : rc_tick;

	lpm_tick_div u_rc_tick
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.run     (rc_osc_powered), // No RC ticks while the RC is unpowered
		.tick    (rc_tick)
	);

	lpm_counter u_wake_cnt
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (cnt_load),
		.value   (cnt_value),
		.step    (cnt_step),
		.done    (cnt_done)
	);

	lpm_counter u_flash_cnt
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (fl_load),
		.value   (FLASH_COUNT),
		.step    (rc_tick),
		.done    (fl_done)
	);

	////////////////////////////////////////////////////////////////////

	// Sequencer next state
	always_comb
	begin
		next_st = st;
		cnt_load = 1'b0;
		cnt_value = RESET_HOLD_CYCLES;
		cnt_step = rc_tick;
		fl_load = 1'b0;
		next_st.brownout_flag = brownout_stage1; // RULE19
		if (any_reset)
		begin
			// Reset wins over any mode or wake count
			next_st.state = ST_RESET; // RULE24
			next_st.mode = REQ_NONE;
			next_st.was_main = 1'b0;
			next_st.rc_source = 1'b1;
			next_st.flash_ok = 1'b0;
			next_st.flash_wait = 1'b0;
			cnt_load = 1'b1; // RULE17
		end
		else
		begin
			case (st.state)
				ST_RESET:
				begin
					// Hold count restarts while the oscillator is down, so rst alone loads it
					cnt_load = !osc_running; // RULE17
					cnt_step = rc_tick & osc_running;
					if (cnt_done && osc_running && flash_init_done) // RULE17
					begin
						next_st.state = ST_RUN;
						next_st.flash_ok = 1'b1;
						next_st.rc_source = 1'b1; // RULE23
					end
				end
				ST_RUN:
				begin
					// Leaves the RC only once software picks the main oscillator
					next_st.rc_source = !main_osc_selected; // RULE23
					if (mode_req_t'(mode_req) != REQ_NONE)
					begin
						next_st.state = (mode_req_t'(mode_req) == REQ_DPD) ? ST_DPD : ST_SLEEP;
						next_st.mode = mode_req_t'(mode_req);
						next_st.was_main = main_osc_selected;
						if (mode_req_t'(mode_req) != REQ_SLEEP)
							next_st.flash_ok = 1'b0; // RULE11
					end
				end
				ST_SLEEP:
				begin
					if (wake_event)
					begin
						if (st.mode == REQ_PDOWN)
						begin
							// RC was off; give it its start-up time
							next_st.state = ST_START;
							next_st.start_cnt = START_CLKS; // RULE12
							next_st.was_main = 1'b0; // RULE23
							next_st.rc_source = 1'b1;
							fl_load = 1'b1; // RULE13
							next_st.flash_wait = 1'b1;
						end
						else
						begin
							next_st.state = ST_WAKE;
							cnt_load = 1'b1;
							cnt_value = st.was_main ? MAIN_WAKE_CYCLES : RC_WAKE_CYCLES; // RULE8 RULE9
						end
					end
				end
				ST_START:
				begin
					if (st.start_cnt <= 10'h001)
					begin
						next_st.state = ST_WAKE;
						cnt_load = 1'b1;
						cnt_value = RC_WAKE_CYCLES; // RULE12
					end
					else
						next_st.start_cnt = st.start_cnt - 10'h001;
				end
				ST_WAKE:
				begin
					cnt_step = osc_tick;
					if (cnt_done)
					begin
						next_st.state = ST_RUN;
						next_st.mode = REQ_NONE;
					end
				end
				ST_DPD:
				begin
					// No state kept; leaving is a full reset sequence
					if (wake_event)
					begin
						next_st.state = ST_RESET; // RULE14
						next_st.mode = REQ_NONE;
						next_st.rc_source = 1'b1;
						cnt_load = 1'b1;
					end
				end
				default:
				begin
					next_st.state = ST_RESET;
				end
			endcase
			// Flash timer frees flash access when it expires
			if (st.flash_wait && fl_done && !fl_load)
			begin
				next_st.flash_wait = 1'b0;
				next_st.flash_ok = 1'b1; // RULE13
			end
		end
	end

	// Register state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st <= '0;
			st.rc_source <= 1'b1;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////

	// Outputs; low-power states hold clocks and pins still
	logic lowp; // Sleep, Power-down or Deep power-down held
	assign lowp = (st.state == ST_SLEEP) || (st.state == ST_DPD);

	assign chip_reset = (st.state == ST_RESET); // RULE17
	assign fetch_address = BOOT_ADDRESS; // RULE18
	assign clocks_enabled = !lowp && (st.state != ST_START); // RULE1
	assign main_osc_enable = !lowp && (st.state != ST_START); // RULE1
	assign rc_osc_powered = !(lowp && st.mode != REQ_SLEEP); // RULE2 RULE11
	assign rc_osc_output_enable = !lowp; // RULE2
	assign rtc_osc_enable = 1'b1; // RULE3
	// PLL stays off until software enables it after wake
	assign pll_enable = 1'b0; // RULE4 RULE10
	assign pll_connect = 1'b0; // RULE4
	assign div_clear = lowp || chip_reset; // RULE5
	assign processor_clock_div = DIV_CLEARED; // RULE5
	assign usb_clock_div = DIV_CLEARED; // RULE5
	assign flash_powered = !(lowp && st.mode != REQ_SLEEP); // RULE7 RULE11
	assign flash_access_allowed = st.flash_ok; // RULE13
	assign regulator_enable = !(st.state == ST_DPD); // RULE14
	assign use_rc_source = st.rc_source; // RULE23
	assign brownout_irq = st.brownout_flag; // RULE19
	assign brownout_status = st.brownout_flag; // RULE19
	assign rtc_alarm_out = rtc_alarm & !main_powered; // RULE22

	////////////////////////////////////////////////////////////////////

	// Reset source forces reset next cycle
	AST_RESET_MERGE: assert property (@(posedge clk_sys) disable iff (rst) // RULE16
		(reset_pin | watchdog_reset | power_on_reset) |=> chip_reset)
		else $error("reset source did not assert chip reset");

	AST_BROWNOUT2_RESET: assert property (@(posedge clk_sys) disable iff (rst) // RULE20
		brownout_stage2 |=> chip_reset)
		else $error("second brownout stage did not reset");

	AST_BROWNOUT1_IRQ: assert property (@(posedge clk_sys) disable iff (rst) // RULE19
		brownout_stage1 |=> (brownout_irq && brownout_status))
		else $error("first brownout stage not flagged");

	AST_RELEASE: assert property (@(posedge clk_sys) disable iff (rst) // RULE17
		$fell(chip_reset) |-> $past(osc_running) && $past(flash_init_done))
		else $error("reset released before oscillator and flash ready");

	AST_SLEEP_CLK: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		(st.state == ST_SLEEP) |-> (!clocks_enabled && !main_osc_enable && div_clear))
		else $error("clocks not gated in sleep");

	AST_SLEEP_RC: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
		(st.state == ST_SLEEP && st.mode == REQ_SLEEP) |-> (rc_osc_powered
		&& !rc_osc_output_enable && flash_powered))
		else $error("sleep oscillator or flash setting wrong");

	AST_PDOWN_OFF: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		(st.state == ST_SLEEP && st.mode == REQ_PDOWN) |-> (!rc_osc_powered && !flash_powered))
		else $error("power-down left oscillator or flash on");

	AST_RC_WAKE: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
		(st.state == ST_SLEEP && st.mode == REQ_SLEEP && !st.was_main && wake_event
		&& !any_reset) |=> (st.state == ST_WAKE) ##[1:12] (st.state == ST_RUN))
		else $error("RC wake did not resume in time");

	AST_DPD_REG: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
		(st.state == ST_DPD) |-> !regulator_enable)
		else $error("regulator on in deep power-down");

endmodule

// ### lpm_pkg.sv
/*
 * Constants and types shared by the low-power mode and reset sequencer.
 * Assumes a single 10 MHz system clock and synchronous active-high reset.
 */
package lpm_pkg;

	// System clock period in ns
	localparam int unsigned CLK_PERIOD_NS = 100;

	// Wake counts in oscillator cycles
	localparam logic [12:0] RC_WAKE_CYCLES   = 13'h0004;
	localparam logic [12:0] MAIN_WAKE_CYCLES = 13'h1000;

	// Oscillator start-up time, us
	localparam int unsigned RC_START_US = 60;
	// Flash start-up time, us
	localparam int unsigned FLASH_START_US = 100;
	// Internal RC oscillator rate, MHz
	localparam int unsigned RC_MHZ = 4;
	// Flash wake count in RC cycles, an exact product so no rounding
	localparam int unsigned FLASH_WAKE_RC = FLASH_START_US * RC_MHZ;

	// Start-up time in system cycles, least time so rounded up
	localparam int unsigned RC_START_CLKS =
		(RC_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Fixed clock count held after reset sources release
	localparam logic [12:0] RESET_HOLD_CYCLES = 13'h0010;

	// Divider ratio producing the RC-rate tick from the system clock
	localparam logic [1:0] RC_TICK_DIV = 2'h2;

	// Processor fetch address after reset release
	localparam logic [31:0] BOOT_ADDRESS = 32'h0000_0000;

	// Cleared value of the clock dividers
	localparam logic [7:0] DIV_CLEARED = 8'h00;

	// Low-power mode requests
	typedef enum logic [1:0]
	{
		REQ_NONE  = 2'h0,
		REQ_SLEEP = 2'h1,
		REQ_PDOWN = 2'h2,
		REQ_DPD   = 2'h3
	} mode_req_t;

	// Sequencer states, Gray coded in the order listed
	typedef enum logic [2:0]
	{
		ST_RESET = 3'b000,
		ST_RUN   = 3'b001,
		ST_SLEEP = 3'b011,
		ST_START = 3'b010,
		ST_WAKE  = 3'b110,
		ST_DPD   = 3'b111
	} seq_state_t;

endpackage

// ### lpm_tick_div.sv
/*
 * Divider producing a one-cycle enable pulse at a slower rate.
 * Assumes clk_sys and synchronous reset; run gates the count.
 */
`timescale 1ns/100ps
module lpm_tick_div
	import lpm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic run,
	output logic      tick
);

	// Module state
	typedef struct packed
	{
		logic [1:0] count;
		logic       tick;
	} div_state_t;

	div_state_t st;      // Registered state
	div_state_t next_st; // Next state

	////////////////////////////////////////////////////////////////////

	// Count down and pulse on wrap
	always_comb
	begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run)
		begin
			// Restart so the first tick is a full period away
			next_st.count = RC_TICK_DIV - 2'h1;
		end
		else if (st.count == 2'h0)
		begin
			next_st.count = RC_TICK_DIV - 2'h1;
			next_st.tick = 1'b1;
		end
		else
		begin
			next_st.count = st.count - 2'h1;
		end
	end

	// Register state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign tick = st.tick;

endmodule

// ### lpm_counter.sv
/*
 * Down counter loaded with a cycle count; done rises when it reaches zero.
 * Assumes clk_sys, synchronous reset; step is an enable pulse.
 */
`timescale 1ns/100ps
module lpm_counter
	import lpm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [12:0] value,
	input  wire logic        step,
	output logic             done
);

	// Module state
	typedef struct packed
	{
		logic [12:0] count;
		logic        done;
	} cnt_state_t;

	cnt_state_t st;      // Registered state
	cnt_state_t next_st; // Next state

	////////////////////////////////////////////////////////////////////

	// Load, then step down to zero
	always_comb
	begin
		next_st = st;
		if (load)
		begin
			next_st.count = value;
			next_st.done = 1'b0;
		end
		else if (step && !st.done)
		begin
			// Done marks the last step so the count itself may stop at zero
			if (st.count <= 13'h0001)
			begin
				next_st.count = 13'h0000;
				next_st.done = 1'b1;
			end
			else
				next_st.count = st.count - 13'h0001;
		end
	end

	// Register state
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign done = st.done;

endmodule

// ### lpm_far_side.sv
/*
 * Far-side model: oscillator amplitude monitor and flash controller start-up.
 * Assumes the sequencer's power outputs, clk_sys and synchronous high rst.
 */
`timescale 1ns/100ps
module lpm_far_side
	import lpm_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic rc_osc_powered,
	input  wire logic flash_powered,
	input  wire logic regulator_enable,
	output logic      osc_running,
	output logic      flash_init_done
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		logic [3:0] osc_cnt;   // Cycles since oscillator power
		logic [3:0] flash_cnt; // Cycles since flash power
	} far_state_t;

	far_state_t state;      // Registered state
	far_state_t next_state; // Next value

	// Start-up counts; loss of power clears them on the next edge, dropping the flags
	always_comb
	begin
		next_state = state;
		if (!rc_osc_powered || !regulator_enable)
			next_state.osc_cnt = 4'h0;
		else if (state.osc_cnt != 4'hF)
			next_state.osc_cnt = state.osc_cnt + 4'h1;
		if (!flash_powered || !regulator_enable)
			next_state.flash_cnt = 4'h0;
		else if (state.flash_cnt != 4'hF)
			next_state.flash_cnt = state.flash_cnt + 4'h1;
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state <= '0;
		else
			state <= next_state;
	end

	// Flags come up only after a few cycles of steady power
	assign osc_running     = (state.osc_cnt >= 4'h6);
	assign flash_init_done = (state.flash_cnt >= 4'hA);
endmodule

// ### tb_lpm_sequencer.sv
/*
 * Self-checking bench for the low-power mode and reset sequencer.
 * Assumes lpm_pkg, the sequencer and the far-side model are compiled first.
 */
`timescale 1ns/100ps
module tb_lpm_sequencer;
	import lpm_pkg::*;
	////////////////////////////////////////////////////////////////////////
	logic        clk_sys = 1'b0, rst = 1'b1;  // Clock and reset
	logic        reset_pin = 1'b0, watchdog_reset = 1'b0;
	logic        power_on_reset = 1'b0, brownout_stage1 = 1'b0;
	logic        brownout_stage2 = 1'b0, main_osc_selected = 1'b0;
	logic [1:0]  mode_req = REQ_NONE;          // Core request
	logic        rtc_alarm = 1'b0, rtc_irq = 1'b0, main_powered = 1'b1;
	logic [3:0]  ext_irq = 4'h0, ext_wake_enable = 4'h0;
	logic        osc_running, flash_init_done; // From far side
	logic        chip_reset, clocks_enabled, main_osc_enable, rc_osc_powered;
	logic        rc_osc_output_enable, rtc_osc_enable, pll_enable, pll_connect;
	logic        div_clear, flash_powered, flash_access_allowed;
	logic        regulator_enable, use_rc_source, brownout_irq;
	logic        brownout_status, rtc_alarm_out;
	logic [31:0] fetch_address;
	logic [7:0]  processor_clock_div, usb_clock_div;
	int          bad_count = 0, tests_run = 0, cycle_count = 0;

	always #50 clk_sys = ~clk_sys;

	lpm_sequencer dut (.clk_sys, .rst, .reset_pin, .watchdog_reset,
		.power_on_reset, .brownout_stage1, .brownout_stage2, .osc_running,
		.flash_init_done, .mode_req, .main_osc_selected, .rtc_alarm, .rtc_irq,
		.ext_irq, .ext_wake_enable, .main_powered, .chip_reset, .fetch_address,
		.clocks_enabled, .main_osc_enable, .rc_osc_powered, .rc_osc_output_enable,
		.rtc_osc_enable, .pll_enable, .pll_connect, .div_clear,
		.processor_clock_div, .usb_clock_div, .flash_powered,
		.flash_access_allowed, .regulator_enable, .use_rc_source,
		.brownout_irq, .brownout_status, .rtc_alarm_out);

	lpm_far_side far (.clk_sys, .rst, .rc_osc_powered, .flash_powered,
		.regulator_enable, .osc_running, .flash_init_done);

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic complete_run();
		if (bad_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One comparison
	task automatic expect_bit(input logic got, input logic exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s", $time, msg);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Wait for chip reset release; too early or never both fail
	task automatic release_reset(input int min_n);
		int n;
		n = 0;
		while (chip_reset !== 1'b0 && n < 300)
		begin
			cycles(1);
			n++;
		end
		expect_bit(n >= min_n && n < 300, 1'b1, "reset release time");
		expect_bit(fetch_address === BOOT_ADDRESS, 1'b1, "fetch address");
		expect_bit(use_rc_source, 1'b1, "runs from rc after reset");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Pin held long keeps reset; release waits the hold count
	task automatic t_reset();
		reset_pin = 1'b1;
		cycles(100);
		expect_bit(chip_reset, 1'b1, "reset held by pin");
		reset_pin = 1'b0;
		release_reset(32);
		expect_bit(processor_clock_div === DIV_CLEARED, 1'b1, "div after reset");
	endtask

	// Each of the four sources resets the chip on the next edge
	task automatic t_sources();
		for (int i = 0; i < 4; i++)
		begin
			{brownout_stage2, power_on_reset, watchdog_reset, reset_pin} = 4'h1 << i;
			cycles(1);
			expect_bit(chip_reset, 1'b1, "source resets chip");
			{brownout_stage2, power_on_reset, watchdog_reset, reset_pin} = 4'h0;
			release_reset(32);
		end
	endtask

	// Sleep entry, refused and accepted wake, resume count, reset exit
	task automatic t_sleep(input logic main, input int lo, input int hi);
		int n;
		main_osc_selected = main;
		mode_req = REQ_SLEEP;
		cycles(1);
		expect_bit(clocks_enabled | main_osc_enable, 1'b0, "sleep clocks");
		expect_bit(rc_osc_output_enable, 1'b0, "rc output off");
		expect_bit(rc_osc_powered, 1'b1, "rc stays powered");
		expect_bit(rtc_osc_enable, 1'b1, "rtc osc runs");
		expect_bit(pll_enable | pll_connect, 1'b0, "pll off");
		expect_bit(div_clear, 1'b1, "dividers cleared");
		expect_bit(usb_clock_div === DIV_CLEARED, 1'b1, "usb div zero");
		expect_bit(flash_powered, 1'b1, "flash on in sleep");
		expect_bit(use_rc_source, !main, "source follows selection");
		ext_irq = 4'hF;
		cycles(20);
		expect_bit(clocks_enabled, 1'b0, "masked irq ignored");
		ext_irq = 4'h0;
		ext_wake_enable = 4'h4;
		ext_irq = main ? 4'h0 : 4'h4;
		rtc_irq = main;
		cycles(1);
		ext_irq = 4'h0;
		rtc_irq = 1'b0;
		ext_wake_enable = 4'h0;
		n = 1;
		while (clocks_enabled !== 1'b1 && n < 20)
		begin
			cycles(1);
			n++;
		end
		// Request still held, so re-entry marks the return to run
		while (clocks_enabled !== 1'b0 && n < hi + 10)
		begin
			cycles(1);
			n++;
		end
		expect_bit(n >= lo && n <= hi, 1'b1, "sleep wake time");
		mode_req = REQ_NONE;
		reset_pin = 1'b1;
		cycles(1);
		expect_bit(chip_reset, 1'b1, "reset ends sleep");
		reset_pin = 1'b0;
		release_reset(32);
	endtask

	// Reset in mid wake count aborts it
	task automatic t_abort();
		main_osc_selected = 1'b1;
		mode_req = REQ_SLEEP;
		cycles(1);
		mode_req = REQ_NONE;
		rtc_irq = 1'b1;
		cycles(1);
		rtc_irq = 1'b0;
		cycles(100);
		watchdog_reset = 1'b1;
		cycles(1);
		expect_bit(chip_reset, 1'b1, "reset aborts wake");
		watchdog_reset = 1'b0;
		release_reset(32);
	endtask

	// Power-down: rc and flash off, start-up wait, flash timer
	task automatic t_pdown();
		int n;
		main_osc_selected = 1'b0;
		mode_req = REQ_PDOWN;
		cycles(1);
		mode_req = REQ_NONE;
		expect_bit(rc_osc_powered | flash_powered, 1'b0, "pdown power");
		expect_bit(clocks_enabled | pll_enable, 1'b0, "pdown as sleep");
		rtc_irq = 1'b1;
		cycles(1);
		rtc_irq = 1'b0;
		cycles(590);
		expect_bit(clocks_enabled, 1'b0, "rc start wait");
		n = 591;
		while (clocks_enabled !== 1'b1 && n < 640)
		begin
			cycles(1);
			n++;
		end
		expect_bit(n >= 600 && n < 640, 1'b1, "pdown resume time");
		expect_bit(use_rc_source, 1'b1, "runs from rc after wake");
		expect_bit(pll_enable | pll_connect, 1'b0, "pll left to software");
		while (n < 795)
		begin
			expect_bit(flash_access_allowed, 1'b0, "flash blocked");
			cycles(1);
			n++;
		end
		while (flash_access_allowed !== 1'b1 && n < 1600)
		begin
			cycles(1);
			n++;
		end
		expect_bit(n < 1600, 1'b1, "flash allowed");
	endtask

	// Deep power-down ignores irqs, alarm restarts as reset
	task automatic t_deep();
		ext_wake_enable = 4'hF;
		mode_req = REQ_DPD;
		cycles(1);
		mode_req = REQ_NONE;
		expect_bit(regulator_enable, 1'b0, "regulator off");
		rtc_irq = 1'b1;
		ext_irq = 4'hF;
		cycles(20);
		expect_bit(regulator_enable | chip_reset, 1'b0, "irq no deep wake");
		rtc_irq = 1'b0;
		ext_irq = 4'h0;
		ext_wake_enable = 4'h0;
		rtc_alarm = 1'b1;
		cycles(1);
		rtc_alarm = 1'b0;
		expect_bit(chip_reset, 1'b1, "alarm wakes as reset");
		release_reset(32);
		expect_bit(regulator_enable, 1'b1, "regulator back");
	endtask

	// First brownout stage: interrupt and status, no reset
	task automatic t_brownout();
		brownout_stage1 = 1'b1;
		cycles(1);
		expect_bit(brownout_irq & brownout_status, 1'b1, "brownout flags");
		expect_bit(chip_reset, 1'b0, "stage one no reset");
		brownout_stage1 = 1'b0;
		cycles(1);
		expect_bit(brownout_irq | brownout_status, 1'b0, "brownout clear");
	endtask

	// Alarm output only while main supply is absent; follows the inputs with no clock edge
	task automatic t_alarm_out();
		rtc_alarm = 1'b1;
		main_powered = 1'b0;
		cycles(1);
		expect_bit(rtc_alarm_out, 1'b1, "alarm out unpowered");
		main_powered = 1'b1;
		cycles(1);
		expect_bit(rtc_alarm_out, 1'b0, "alarm out powered");
		rtc_alarm = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Hang guard, ceiling well above the roughly 5500 cycles needed
	always @(posedge clk_sys)
	begin
		cycle_count++;
		if (cycle_count == 20000)
		begin
			bad_count++;
			$display("MISMATCH t=%0t timeout", $time);
			complete_run();
		end
	end

	// Main sequence
	initial
	begin
		cycles(12);
		rst = 1'b0;
		cycles(1);
		expect_bit(chip_reset, 1'b1, "reset after rst");
		release_reset(32);
		t_reset();
		t_sources();
		t_sleep(1'b0, 8, 16);
		t_sleep(1'b1, 4096, 4110);
		t_abort();
		t_pdown();
		t_deep();
		t_brownout();
		t_alarm_out();
		complete_run();
	end
endmodule
